// File: src/gpiop_pkg.sv
// Register map, reset values and encodings for the general I/O port block
`default_nettype none
package gpiop_pkg;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned ADDR_W = 8;
  // Register offsets
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_DIR = 8'h01;
  localparam logic [7:0] OFS_OPT = 8'h02;
  localparam logic [7:0] OFS_SENS = 8'h03;
  localparam logic [7:0] OFS_SEL = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h05;
  // Reset values
  localparam logic [7:0] RST_DATA = 8'hFF;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_OPT = 8'h40;
  localparam logic [1:0] RST_SENS = 2'h0;
  localparam logic [1:0] RST_SEL = 2'h0;
  // Pins able to raise the external request
  localparam logic [7:0] IRQ_PIN_MASK = 8'h7E;
  // Field positions
  localparam int unsigned SENS_LSB = 0;
  localparam int unsigned SEL_LSB = 0;
  localparam int unsigned STAT_PEND_BIT = 0;
  // Sensitivity encoding
  typedef enum logic [1:0] {
    GPIOP_SENS_FALL_LOW = 2'h0,
    GPIOP_SENS_RISE = 2'h1,
    GPIOP_SENS_FALL = 2'h2,
    GPIOP_SENS_BOTH = 2'h3
  } gpiop_sens_t;
endpackage : gpiop_pkg
`default_nettype wire

// File: src/gpiop_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`default_nettype none
module gpiop_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // First stage feeds only the second stage
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : gpiop_sync
`default_nettype wire

// File: src/gpiop_port.sv
// General-purpose 8-bit I/O port with external interrupt and alternate functions
// How it works
// - One port of eight pins, each pin input or output on its own.
// - Bit x of data, direction and option registers controls pin x.
// - Direction zero makes an input; reading data returns sampled pin level.
// - Writing data of an input pin only updates the latch.
// - Input option zero floats, option one enables the pull-up.
// - Direction one drives the latch out; reading data returns the latch.
// - Output option one push-pull, zero open-drain; zero drives low always.
// - Capable input pins raise the external request when pin select is nonzero.
// - Sensitivity register picks falling, rising, both, or falling plus low level.
// - Vector fetch clears the request latch unless an event hits in the same cycle.
// - A write changing sensitivity discards any pending request.
// - Request reaches the CPU only when configured and global mask clear.
// - Low-power modes leave port alone; external request wakes the device.
// - Peripheral output enable overrides direction and data of the pin.
// - Input pin with alternate output reads back the alternate level.
// - Output pin feeds the latch value to the alternate input.
// - With pin select nonzero, option zero floats and one pulls up, both interrupting.
// - Reset: data all ones, direction zero, option 0x40.
`default_nettype none
module gpiop_port (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup_en,
  input wire logic [7:0] alt_out_en,
  input wire logic [7:0] alt_out,
  output logic [7:0] alt_in,
  input wire logic cpu_irq_mask,
  input wire logic vector_fetch,
  output logic ext_irq_req,
  output logic wake_req
);
  logic [7:0] data_q, data_d;
  logic [7:0] dir_q, dir_d;
  logic [7:0] opt_q, opt_d;
  logic [1:0] sens_q, sens_d;
  logic [1:0] sel_q, sel_d;
  logic pend_q, pend_d;
  logic [7:0] prev_q, prev_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] pin_s;
  logic [7:0] irq_en;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] port_rd;
  logic event_hit;
  logic sens_change;

  // Pins are asynchronous to core_clk
  gpiop_sync #(.WIDTH(8)) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in(pin_in),
    .sync_out(pin_s)
  );

  // Per-pin pad and readback logic
  for (genvar i = 0; i < 8; i++) begin : g_pin
    always_comb begin
      if (alt_out_en[i]) begin
        pin_out[i] = alt_out[i];
        pin_oe[i] = 1'b1;
      end else if (dir_q[i]) begin
        pin_out[i] = 1'b0;
        pin_oe[i] = opt_q[i] | ~data_q[i];
        if (opt_q[i]) begin
          pin_out[i] = data_q[i];
        end
      end else begin
        pin_out[i] = 1'b0;
        pin_oe[i] = 1'b0;
      end
      pin_pullup_en[i] = ~dir_q[i] & ~alt_out_en[i] & opt_q[i];
      if (dir_q[i]) begin
        port_rd[i] = data_q[i];
      end else if (alt_out_en[i]) begin
        port_rd[i] = alt_out[i];
      end else begin
        port_rd[i] = pin_s[i];
      end
      alt_in[i] = dir_q[i] ? data_q[i] : pin_s[i];
      irq_en[i] = ~dir_q[i] & gpiop_pkg::IRQ_PIN_MASK[i] & (sel_q != 2'h0);
      rise[i] = irq_en[i] & pin_s[i] & ~prev_q[i];
      fall[i] = irq_en[i] & ~pin_s[i] & prev_q[i];
    end
  end

  // Event detection per sensitivity
  always_comb begin
    unique case (gpiop_pkg::gpiop_sens_t'(sens_q))
      gpiop_pkg::GPIOP_SENS_FALL_LOW: event_hit = |(irq_en & ~pin_s);
      gpiop_pkg::GPIOP_SENS_RISE: event_hit = |rise;
      gpiop_pkg::GPIOP_SENS_FALL: event_hit = |fall;
      gpiop_pkg::GPIOP_SENS_BOTH: event_hit = |(rise | fall);
    endcase
  end

  assign sens_change = reg_wr && reg_addr == gpiop_pkg::OFS_SENS
    && reg_wdata[gpiop_pkg::SENS_LSB +: 2] != sens_q;

  // Register file and request latch
  always_comb begin
    data_d = data_q;
    dir_d = dir_q;
    opt_d = opt_q;
    sens_d = sens_q;
    sel_d = sel_q;
    prev_d = pin_s;
    rdata_d = 8'h00;
    if (reg_wr) begin
      unique case (reg_addr)
        gpiop_pkg::OFS_DATA: data_d = reg_wdata;
        gpiop_pkg::OFS_DIR: dir_d = reg_wdata;
        gpiop_pkg::OFS_OPT: opt_d = reg_wdata;
        gpiop_pkg::OFS_SENS: sens_d = reg_wdata[gpiop_pkg::SENS_LSB +: 2];
        gpiop_pkg::OFS_SEL: sel_d = reg_wdata[gpiop_pkg::SEL_LSB +: 2];
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        gpiop_pkg::OFS_DATA: rdata_d = port_rd;
        gpiop_pkg::OFS_DIR: rdata_d = dir_q;
        gpiop_pkg::OFS_OPT: rdata_d = opt_q;
        gpiop_pkg::OFS_SENS: rdata_d = {6'h00, sens_q};
        gpiop_pkg::OFS_SEL: rdata_d = {6'h00, sel_q};
        gpiop_pkg::OFS_STAT: rdata_d = {7'h00, pend_q};
        default: rdata_d = 8'h00;
      endcase
    end
    // Set beats a vector fetch in the same cycle; a sensitivity change wins over both
    pend_d = pend_q;
    if (vector_fetch) begin
      pend_d = 1'b0;
    end
    if (event_hit) begin
      pend_d = 1'b1;
    end
    if (sens_change) begin
      pend_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      data_q <= gpiop_pkg::RST_DATA;
      dir_q <= gpiop_pkg::RST_DIR;
      opt_q <= gpiop_pkg::RST_OPT;
      sens_q <= gpiop_pkg::RST_SENS;
      sel_q <= gpiop_pkg::RST_SEL;
      pend_q <= 1'b0;
      prev_q <= 8'h00;
      rdata_q <= 8'h00;
    end else begin
      data_q <= data_d;
      dir_q <= dir_d;
      opt_q <= opt_d;
      sens_q <= sens_d;
      sel_q <= sel_d;
      pend_q <= pend_d;
      prev_q <= prev_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  // Wake ignores the global mask so a masked CPU still leaves WAIT or HALT
  assign ext_irq_req = pend_q & (|irq_en) & ~cpu_irq_mask;
  assign wake_req = pend_q & (|irq_en);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Pad checks watch single pins, a_input_hiz the whole port; the generate loop makes the others alike
  a_od_release: assert property (
    !alt_out_en[0] && dir_q[0] && !opt_q[0] && data_q[0]
    |-> !pin_oe[0])
    else $error("open-drain high still driven");
  a_od_low: assert property (
    !alt_out_en[0] && dir_q[0] && !data_q[0]
    |-> pin_oe[0] && !pin_out[0])
    else $error("latch zero not driving low");
  a_pp_drive: assert property (
    !alt_out_en[0] && dir_q[0] && opt_q[0]
    |-> pin_oe[0] && pin_out[0] == data_q[0])
    else $error("push-pull pin not driving latch");
  a_input_hiz: assert property (
    dir_q == 8'h00 && alt_out_en == 8'h00
    |-> pin_oe == 8'h00)
    else $error("input pin driven");
  a_pullup_in: assert property (
    !dir_q[6] && !alt_out_en[6]
    |-> pin_pullup_en[6] == opt_q[6])
    else $error("input pull-up not following option");
  a_out_no_pull: assert property (
    dir_q[6]
    |-> !pin_pullup_en[6])
    else $error("pull-up on output pin");
  a_alt_override: assert property (
    alt_out_en[3]
    |-> pin_oe[3] && pin_out[3] == alt_out[3])
    else $error("alternate output not on pin");
  a_alt_dir_over: assert property (
    alt_out_en[0] && dir_q[0]
    |-> pin_oe[0] && pin_out[0] == alt_out[0])
    else $error("alternate output lost to port output");
  a_alt_in: assert property (
    dir_q[1]
    |-> alt_in[1] == data_q[1])
    else $error("alternate input not latch");

  // Readback lands one cycle after the strobe and only then
  a_rd_output: assert property (
    reg_rd && reg_addr == gpiop_pkg::OFS_DATA && dir_q[2]
    |=> reg_rdata[2] == $past(data_q[2]))
    else $error("output readback not latch");
  a_rd_sync: assert property (
    reg_rd && reg_addr == gpiop_pkg::OFS_DATA && !dir_q[5] && !alt_out_en[5]
    |=> reg_rdata[5] == $past(pin_in[5], 3))
    else $error("input readback not pin after sync");
  a_alt_rd: assert property (
    reg_rd && reg_addr == gpiop_pkg::OFS_DATA && !dir_q[2] && alt_out_en[2]
    |=> reg_rdata[2] == $past(alt_out[2]))
    else $error("input readback not alternate level");
  a_rd_stat: assert property (
    reg_rd && reg_addr == gpiop_pkg::OFS_STAT
    |=> reg_rdata == {7'h00, $past(pend_q)})
    else $error("status readback not pending flag");
  a_wr_latch: assert property (
    reg_wr && reg_addr == gpiop_pkg::OFS_DATA
    |=> data_q == $past(reg_wdata))
    else $error("data write missed the latch");
  a_dir_wr: assert property (
    reg_wr && reg_addr == gpiop_pkg::OFS_DIR
    |=> dir_q == $past(reg_wdata))
    else $error("direction write lost");
  a_sync_two: assert property (
    $past(reset_n) && $past(reset_n, 2)
    |-> pin_s == $past(pin_in, 2))
    else $error("pin path not two flops deep");

  // Level mode keeps setting while the pin is low, so set must beat a fetch
  a_edge_set: assert property (
    event_hit && !sens_change
    |=> pend_q)
    else $error("event did not latch request");
  a_opt_zero_irq: assert property (
    sel_q != 2'h0 && !dir_q[3] && !opt_q[3] && sens_q == 2'h2
    && $past(pin_s[3]) && !pin_s[3] && !sens_change
    |=> pend_q)
    else $error("floating pin edge ignored");
  a_rise_only: assert property (
    sens_q == 2'h1 && pin_s == $past(pin_s)
    |-> !event_hit)
    else $error("rising mode fired on steady pins");
  a_sens_hold: assert property (
    !(reg_wr && reg_addr == gpiop_pkg::OFS_SENS)
    |=> sens_q == $past(sens_q))
    else $error("sensitivity changed without a write");
  a_fetch_clear: assert property (
    vector_fetch && !event_hit
    |=> !pend_q)
    else $error("fetch left request pending");
  a_fetch_set: assert property (
    vector_fetch && event_hit && !sens_change
    |=> pend_q)
    else $error("fetch beat a fresh event");
  a_sens_clear: assert property (
    sens_change
    |=> !pend_q)
    else $error("sensitivity change kept request");
  a_mask_gate: assert property (
    cpu_irq_mask
    |-> !ext_irq_req)
    else $error("request passed global mask");
  a_sel_off: assert property (
    sel_q == 2'h0
    |-> !ext_irq_req && !wake_req)
    else $error("request without pin select");
  a_wake_idle: assert property (
    !pend_q
    |-> !wake_req && !ext_irq_req)
    else $error("wake without pending request");
  a_wake_mask: assert property (
    pend_q && !dir_q[3] && sel_q != 2'h0
    |-> wake_req)
    else $error("pending request did not wake");
  a_rst_vals: assert property (
    $rose(reset_n)
    |-> data_q == gpiop_pkg::RST_DATA && dir_q == gpiop_pkg::RST_DIR
    && opt_q == gpiop_pkg::RST_OPT)
    else $error("reset values wrong");

  c_irq: cover property (ext_irq_req ##[1:20] vector_fetch);
  c_wake_masked: cover property (wake_req && cpu_irq_mask);
  c_alt_read: cover property (reg_rd && reg_addr == gpiop_pkg::OFS_DATA && |(alt_out_en & ~dir_q));
  c_od_out: cover property (dir_q[0] && !opt_q[0] && !data_q[0]);
  c_fetch_level: cover property (vector_fetch && event_hit);
endmodule : gpiop_port
`default_nettype wire

// File: tb/gpiop_pins_model.sv
// Pin-side model: resolves each pad from the port, an outside driver and the pull-up
`default_nettype none
module gpiop_pins_model (
  input wire logic core_clk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup_en,
  input wire logic [7:0] drv_en,
  input wire logic [7:0] drv_val,
  output logic [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] float_q = 8'h00;
  // Undriven pads wander so a stale level never reads as valid
  always @(posedge core_clk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (drv_en[i]) pin_in[i] = drv_val[i];
      else if (pin_pullup_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_q[i];
    end
  end
endmodule : gpiop_pins_model
`default_nettype wire

// File: tb/gpiop_port_tb_top.sv
// Self-checking bench for the general I/O port block
`default_nettype none
module gpiop_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] dir, opt, dat, xen, xv, aen, av, oe, out, pu, rd, ain;
  } gpiop_row_t;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, cpu_irq_mask = 1'b1, vector_fetch = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, alt_out_en = 8'h00, alt_out = 8'h00;
  logic [7:0] drv_en = 8'h00, drv_val = 8'h00;
  logic [7:0] reg_rdata, pin_in, pin_out, pin_oe, pu_en, alt_in, rdv;
  logic ext_irq_req, wake_req;
  logic [7:0] irqv;
  int err_total = 0, check_count = 0;
  // Pad setup and inputs beside the pads, readback and peripheral input they give
  gpiop_row_t rows [5] = '{
    96'hFF_FF_A5_00_00_00_00_FF_A5_00_A5_A5, 96'hFF_00_A5_00_00_00_00_5A_00_00_A5_A5,
    96'h00_0F_3C_FF_96_00_00_00_00_0F_96_96, 96'h0F_F0_C3_F0_50_00_00_0C_00_F0_53_53,
    96'hF1_0F_0F_00_00_0F_0A_FF_0A_00_0B_0B};
  assign irqv = {6'h00, wake_req, ext_irq_req};
  always #2.5 core_clk = ~core_clk;
  gpiop_port DUT (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pu_en),
    .alt_out_en(alt_out_en), .alt_out(alt_out), .alt_in(alt_in),
    .cpu_irq_mask(cpu_irq_mask), .vector_fetch(vector_fetch),
    .ext_irq_req(ext_irq_req), .wake_req(wake_req));
  gpiop_pins_model PADS (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pu_en), .drv_en(drv_en), .drv_val(drv_val), .pin_in(pin_in));
  task automatic stop_test;
    $display("Checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rdv = reg_rdata;
  endtask : rd
  task automatic fetch;
    @(posedge core_clk);
    vector_fetch <= 1'b1;
    @(posedge core_clk);
    vector_fetch <= 1'b0;
  endtask : fetch
  // Four cycles cover the two-flop pin path plus the request flop
  task automatic pin(input logic [7:0] v);
    @(posedge core_clk);
    drv_val <= v;
    cyc(4);
  endtask : pin
  initial begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    stop_test;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      wr(gpiop_pkg::OFS_DIR, rows[i].dir);
      wr(gpiop_pkg::OFS_OPT, rows[i].opt);
      wr(gpiop_pkg::OFS_DATA, rows[i].dat);
      drv_en <= rows[i].xen;
      drv_val <= rows[i].xv;
      alt_out_en <= rows[i].aen;
      alt_out <= rows[i].av;
      cyc(4);
      chk(pin_oe, rows[i].oe);
      chk(pin_out, rows[i].out);
      chk(pu_en, rows[i].pu);
      chk(alt_in, rows[i].ain);
      rd(gpiop_pkg::OFS_DATA);
      chk(rdv, rows[i].rd);
    end
    rd(8'h3F);
    chk(rdv, 8'h00);
    alt_out_en <= 8'h00;
    drv_en <= 8'hFF;
    drv_val <= 8'hFF;
    wr(gpiop_pkg::OFS_DIR, 8'h00);
    wr(gpiop_pkg::OFS_OPT, 8'h00);
    cyc(1);
    chk(pu_en, 8'h00);
    chk(pin_oe, 8'h00);
    wr(gpiop_pkg::OFS_OPT, 8'h81);
    wr(gpiop_pkg::OFS_SEL, 8'h01);
    wr(gpiop_pkg::OFS_SENS, 8'h02);
    pin(8'h7E);
    chk(irqv, 8'h00);
    @(posedge core_clk);
    drv_val <= 8'h76;
    cyc(2);
    chk(irqv, 8'h00);
    cyc(1);
    chk(irqv, 8'h02);
    @(posedge core_clk);
    cpu_irq_mask <= 1'b0;
    cyc(0);
    chk(irqv, 8'h03);
    rd(gpiop_pkg::OFS_STAT);
    chk(rdv, 8'h01);
    wr(gpiop_pkg::OFS_SENS, 8'h03);
    cyc(1);
    chk(irqv, 8'h00);
    for (int m = 0; m < 4; m++) begin
      pin(8'h7E);
      wr(gpiop_pkg::OFS_SENS, 8'(m));
      pin(8'h76);
      chk(irqv, m != 1 ? 8'h03 : 8'h00);
      fetch;
      cyc(3);
      chk(irqv, m == 0 ? 8'h03 : 8'h00);
      pin(8'h7E);
      chk(irqv, m != 2 ? 8'h03 : 8'h00);
      fetch;
      cyc(1);
      chk(irqv, 8'h00);
    end
    wr(gpiop_pkg::OFS_DIR, 8'hFF);
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    cyc(0);
    chk(pu_en, 8'h40);
    rd(gpiop_pkg::OFS_OPT);
    chk(rdv, 8'h40);
    rd(gpiop_pkg::OFS_DIR);
    chk(rdv, 8'h00);
    wr(gpiop_pkg::OFS_DIR, 8'hFF);
    rd(gpiop_pkg::OFS_DATA);
    chk(rdv, 8'hFF);
    stop_test;
  end
endmodule : gpiop_port_tb_top
`default_nettype wire
